// >>> logic/emb_mem_pkg.sv
// Purpose: shared constants and types for the embedded memory block wrapper
// Assumes: one 100 MHz reference clock, APB register access
// Notes: widths here size the packed structs, so they live in the package
package emb_mem_pkg;
    localparam int DATA_W = 16; // word width of the memory
    localparam int ADDR_W = 8; // address width, depth is 2**ADDR_W
    localparam int DEPTH = 1 << ADDR_W; // number of words
    localparam int APB_AW = 12; // apb byte address width
    localparam int CLK_PERIOD_NS = 10; // reference clock period

    // register byte addresses
    localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000; // control word
    localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004; // state readback

    // control field positions
    localparam int CTRL_REG_WR_DATA = 0; // register write data
    localparam int CTRL_REG_RD_OUT = 1; // register read data output
    localparam int CTRL_REG_RD_ADDR = 2; // register read address
    localparam int CTRL_REG_WR_ADDR = 3; // register write address
    localparam int CTRL_REG_WR_STB = 4; // register write strobe
    localparam int CTRL_REG_RD_STB = 5; // register read strobe
    localparam int CTRL_SINGLE_PORT = 6; // single-port mode
    localparam int CTRL_WR_STB_GLOBAL = 7; // write strobe from global signal
    localparam int CTRL_RD_STB_GLOBAL = 8; // read strobe from global signal
    localparam int CTRL_W = 9; // implemented control bits
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h03F; // all paths registered

    // status field positions
    localparam int STAT_RD_DATA_LSB = 0; // read data output copy
    localparam int STAT_IN_CLEAR = 16; // input side held in clear
    localparam int STAT_OUT_CLEAR = 17; // output side held in clear
    localparam int STAT_DEV_CLEAR = 18; // device-wide clear active

    // fabric-side request bundle captured by the input registers
    typedef struct packed {
        logic [DATA_W-1:0] wr_data; // data to store
        logic [ADDR_W-1:0] wr_addr; // store location
        logic [ADDR_W-1:0] rd_addr; // fetch location
        logic wr_strobe; // write strobe
        logic read_strobe; // read strobe
    } mem_req_t;

    // strobe sources, one local and one global per strobe
    typedef struct packed {
        logic wr_local; // write strobe from logic cells
        logic wr_global; // write strobe from global signal
        logic rd_local; // read strobe from logic cells
        logic rd_global; // read strobe from global signal
    } strobe_src_t;
endpackage

// >>> logic/embedded_memory_block.sv
// Purpose: embedded memory block with selectable input/output registering
// Assumes: side clocks, clears and device-wide clear come from pins; data,
//          addresses, strobes and enables come from logic cells on i_ref_clk
// Notes: side clocks are sampled, so a side clock must stay below half the
//        reference rate; clears act on the synchronised level at once
//
// Behaviour
// R1: two separate clocks for input and output sides
// R2: input clock drives all input registers
// R3: output clock drives only read data registers
// R4: per-side clock enable and clear, independent
// R5: local clear clears its own side; global or device-wide clear clears both
// R6: single-port mode, no simultaneous read and write
// R7: each path registered or passed through, selectable
// R8: strobes from global signals or local routing
// R9: device-wide clear overrides every other control
// R10: device-wide clear honoured only when build option set
// R11: enabled input edge with write strobe stores word
// R12: read strobe presents word; output edge captures it
`timescale 1ns/1ps
`default_nettype none
module embedded_memory_block
    import emb_mem_pkg::*;
#(
    parameter bit DEV_CLR_ENABLE = 1'b1 // build option for device-wide clear
) (
    input wire logic i_ref_clk, // 100 mhz reference clock
    input wire logic i_reset, // synchronous reset, active high
    input wire logic i_in_clk, // input-side clock pin
    input wire logic i_out_clk, // output-side clock pin
    input wire logic i_in_clk_en, // input-side clock enable
    input wire logic i_out_clk_en, // output-side clock enable
    input wire logic i_in_clear, // input-side clear from local routing
    input wire logic i_out_clear, // output-side clear from local routing
    input wire logic i_global_clear, // global clear signal
    input wire logic i_device_wide_clear_n, // device-wide clear, active low
    input wire emb_mem_pkg::mem_req_t i_req, // data and addresses
    input wire emb_mem_pkg::strobe_src_t i_strobe, // strobe sources
    output logic [emb_mem_pkg::DATA_W-1:0] o_rd_data, // read data output
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic i_pwrite, // apb direction
    input wire logic [emb_mem_pkg::APB_AW-1:0] i_paddr, // apb byte address
    input wire logic [31:0] i_pwdata, // apb write data
    output logic [31:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr // apb error on unmapped address
);
    import emb_mem_pkg::*;

    logic [DATA_W-1:0] mem [DEPTH]; // storage array
    logic [CTRL_W-1:0] ctrl; // control register
    logic [2:0] in_clk_sync; // input clock sampler, bit 2 is previous
    logic [2:0] out_clk_sync; // output clock sampler
    logic [1:0] in_clr_sync; // local input clear synchroniser
    logic [1:0] out_clr_sync; // local output clear synchroniser
    logic [1:0] glb_clr_sync; // global clear synchroniser
    logic [1:0] dev_clr_sync; // device-wide clear synchroniser
    mem_req_t req_reg; // input registers
    logic [DATA_W-1:0] out_reg; // output register
    mem_req_t live; // live request with strobes from the chosen source
    mem_req_t eff; // request after register bypass
    logic in_edge; // rising edge of input clock
    logic out_edge; // rising edge of output clock
    logic dev_clear; // device-wide clear in force
    logic in_clr; // input side clear
    logic out_clr; // output side clear
    logic rd_en; // effective read after single-port gating
    logic [ADDR_W-1:0] rd_addr; // effective read address
    logic [DATA_W-1:0] rd_word; // word being presented
    logic apb_take; // apb access completes this edge
    logic mapped; // address decodes to a register

    // side clocks and clears come from pins: two flops before any use
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            in_clk_sync <= '0;
            out_clk_sync <= '0;
            in_clr_sync <= '0;
            out_clr_sync <= '0;
            glb_clr_sync <= '0;
            dev_clr_sync <= 2'h3; // idle high
        end
        else
        begin
            in_clk_sync <= {in_clk_sync[1:0], i_in_clk}; // [R1]
            out_clk_sync <= {out_clk_sync[1:0], i_out_clk}; // [R1]
            in_clr_sync <= {in_clr_sync[0], i_in_clear};
            out_clr_sync <= {out_clr_sync[0], i_out_clear};
            glb_clr_sync <= {glb_clr_sync[0], i_global_clear};
            dev_clr_sync <= {dev_clr_sync[0], i_device_wide_clear_n};
        end
    end

    // edge detect reads only the second and third flops
    assign in_edge = in_clk_sync[1] & ~in_clk_sync[2]; // [R1]
    assign out_edge = out_clk_sync[1] & ~out_clk_sync[2]; // [R1]

    // device-wide clear ignored unless the build option enables it
    assign dev_clear = DEV_CLR_ENABLE & ~dev_clr_sync[1]; // [R10]
    // each side has its own local clear; global and device clears hit both
    assign in_clr = dev_clear | glb_clr_sync[1] | in_clr_sync[1]; // [R4] [R5]
    assign out_clr = dev_clear | glb_clr_sync[1] | out_clr_sync[1]; // [R4] [R5]

    // strobe source select, then bypass mux per path; the input registers
    // capture the same live bundle so both paths agree on the source
    always_comb
    begin
        live = i_req;
        live.wr_strobe = ctrl[CTRL_WR_STB_GLOBAL] ? i_strobe.wr_global
                                                  : i_strobe.wr_local; // [R8]
        live.read_strobe = ctrl[CTRL_RD_STB_GLOBAL] ? i_strobe.rd_global
                                                    : i_strobe.rd_local; // [R8]
        eff.wr_data = ctrl[CTRL_REG_WR_DATA] ? req_reg.wr_data : live.wr_data; // [R7]
        eff.wr_addr = ctrl[CTRL_REG_WR_ADDR] ? req_reg.wr_addr : live.wr_addr; // [R7]
        eff.rd_addr = ctrl[CTRL_REG_RD_ADDR] ? req_reg.rd_addr : live.rd_addr; // [R7]
        eff.wr_strobe = ctrl[CTRL_REG_WR_STB] ? req_reg.wr_strobe : live.wr_strobe; // [R7]
        eff.read_strobe = ctrl[CTRL_REG_RD_STB] ? req_reg.read_strobe
                                                : live.read_strobe; // [R7]
    end

    // input registers: input clock only, its own enable and clear
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || in_clr)
        begin
            req_reg <= '0; // clear wins over enable [R5] [R9]
        end
        else if (in_edge && i_in_clk_en)
        begin
            req_reg <= live; // [R2] [R4]
        end
    end

    // single-port mode shares the write address and never reads during a write
    assign rd_en = eff.read_strobe
                   & ~(ctrl[CTRL_SINGLE_PORT] & eff.wr_strobe); // [R6]
    assign rd_addr = ctrl[CTRL_SINGLE_PORT] ? eff.wr_addr : eff.rd_addr; // [R6]
    assign rd_word = mem[rd_addr]; // [R12]

    // storage write on an enabled input edge; array itself is not cleared
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset && !in_clr && in_edge && i_in_clk_en && eff.wr_strobe)
        begin
            mem[eff.wr_addr] <= eff.wr_data; // [R11]
        end
    end

    // output register: output clock only, its own enable and clear
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || out_clr)
        begin
            out_reg <= '0; // [R4] [R5] [R9]
        end
        else if (out_edge && i_out_clk_en && rd_en)
        begin
            out_reg <= rd_word; // [R3] [R12]
        end
    end

    // output pin flop: follows the output register, or the live word when
    // bypassed; bypass costs one reference cycle of retiming
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || out_clr)
        begin
            o_rd_data <= '0; // [R5]
        end
        else if (ctrl[CTRL_REG_RD_OUT])
        begin
            o_rd_data <= out_reg; // [R7]
        end
        else if (rd_en)
        begin
            o_rd_data <= rd_word; // unregistered path [R7] [R12]
        end
    end

    // apb: one wait state, effect at the edge where pready is seen high
    assign apb_take = i_psel & i_penable & o_pready;
    assign mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS);

    // control register; the device-wide clear resets it too
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || dev_clear)
        begin
            ctrl <= CTRL_RESET; // [R9]
        end
        else if (apb_take && i_pwrite && i_paddr == ADDR_CTRL)
        begin
            ctrl <= i_pwdata[CTRL_W-1:0];
        end
    end

    // apb answer: ready, error and read data all from flops
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end
        else if (i_psel && i_penable && !o_pready)
        begin
            o_pready <= 1'b1;
            o_pslverr <= ~mapped; // unmapped: error, data zero
            o_prdata <= '0;
            if (!i_pwrite && i_paddr == ADDR_CTRL)
            begin
                o_prdata[CTRL_W-1:0] <= ctrl;
            end
            else if (!i_pwrite && i_paddr == ADDR_STATUS)
            begin
                o_prdata[STAT_RD_DATA_LSB +: DATA_W] <= o_rd_data;
                o_prdata[STAT_IN_CLEAR] <= in_clr;
                o_prdata[STAT_OUT_CLEAR] <= out_clr;
                o_prdata[STAT_DEV_CLEAR] <= dev_clear;
            end
        end
        else
        begin
            o_pready <= 1'b0; // drop after the completing edge
            o_pslverr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verification/emb_mem_chk.sv
// Purpose: port checks for the memory block wrapper
// Assumes: bound to embedded_memory_block, one reference clock
// Notes: clear checks allow sync latency plus the output flop
`timescale 1ns/1ps
`default_nettype none
module emb_mem_chk
    import emb_mem_pkg::*;
#(
    parameter bit DEV_CLR_ENABLE = 1'b1 // same build option as the block
) (
    input wire logic i_ref_clk, // reference clock
    input wire logic i_reset, // sync reset
    input wire logic i_out_clear, // output-side clear
    input wire logic i_global_clear, // global clear
    input wire logic i_device_wide_clear_n, // device-wide clear, low active
    input wire logic [DATA_W-1:0] o_rd_data, // read data
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic [APB_AW-1:0] i_paddr, // apb address
    input wire logic o_pready, // apb ready
    input wire logic o_pslverr // apb error
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    // bus answer comes after one wait state and lasts one cycle
    pready_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("ready missing after wait state");
    pready_one_a: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    pready_acc_a: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside access phase");
    // only the two mapped words answer without error
    bad_addr_a: assert property (o_pready && i_paddr != ADDR_CTRL && i_paddr != ADDR_STATUS
        |-> o_pslverr)
        else $error("unmapped address not refused");
    good_addr_a: assert property (o_pready && (i_paddr == ADDR_CTRL || i_paddr == ADDR_STATUS)
        |-> !o_pslverr)
        else $error("mapped address refused");
    // clears win over edges and enables once past the synchroniser
    out_clear_a: assert property (i_out_clear [*4] |-> o_rd_data == '0)
        else $error("output clear ignored");
    glob_clear_a: assert property (i_global_clear [*4] |-> o_rd_data == '0)
        else $error("global clear ignored");
    dev_clear_a: assert property ((DEV_CLR_ENABLE && !i_device_wide_clear_n) [*4] |-> o_rd_data == '0)
        else $error("device clear ignored");
    reset_vals_a: assert property (disable iff (1'b0) i_reset |=> o_rd_data == '0 && !o_pready)
        else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// >>> verification/side_clk_gen.sv
// Purpose: fabric model making one side clock of the memory block
// Assumes: driven from the bench on the reference clock
// Notes: stands low between bursts, like a gated fabric clock
`timescale 1ns/1ps
`default_nettype none
module side_clk_gen (
    input wire logic i_ref_clk, // reference clock
    input wire logic i_go, // run request
    output logic o_clk // side clock, low when idle
);
    logic [2:0] cnt = 3'h0; // phase in a six-cycle period
    // three cycles per phase keeps each level past the two-flop sampler
    always_ff @(posedge i_ref_clk)
    begin
        if (i_go || cnt != 3'h0)
            cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
    end
    assign o_clk = (cnt != 3'h0) && (cnt < 3'h4);
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: self-checking bench for the memory block wrapper
// Assumes: side clocks from side_clk_gen, registers over apb
// Notes: the table walks registering modes, hand tests cover clears
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import emb_mem_pkg::*;
    logic i_ref_clk, i_reset = 1'b1, in_go = 1'b0, out_go = 1'b0;
    wire logic in_clk, out_clk;
    logic in_en = 1'b1, out_en = 1'b1, in_clr = 1'b0, out_clr = 1'b0;
    logic glb_clr = 1'b0, dev_n = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    mem_req_t req = '0;
    strobe_src_t stb = '0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [DATA_W-1:0] rd_data;
    logic pready, pslverr, e;
    logic [8:0] c;
    logic [7:0] a;
    logic [15:0] d;
    logic [2:0] cl;
    int mismatches = 0, n_checks = 0, cyc = 0;
    // control word, address, data written then expected back
    logic [32:0] rows [5] = '{{9'h03F, 8'h00, 16'h1234}, {9'h000, 8'hFF, 16'hFFFF},
        {9'h07F, 8'h3C, 16'h0F0F}, {9'h180, 8'h81, 16'h8001}, {9'h1D5, 8'h7E, 16'hA5C3}};
    side_clk_gen in_u (.i_ref_clk(i_ref_clk), .i_go(in_go), .o_clk(in_clk));
    side_clk_gen out_u (.i_ref_clk(i_ref_clk), .i_go(out_go), .o_clk(out_clk));
    embedded_memory_block dut_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_in_clk(in_clk), .i_out_clk(out_clk), .i_in_clk_en(in_en),
        .i_out_clk_en(out_en), .i_in_clear(in_clr), .i_out_clear(out_clr),
        .i_global_clear(glb_clr), .i_device_wide_clear_n(dev_n), .i_req(req),
        .i_strobe(stb), .o_rd_data(rd_data), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr));
    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic end_of_test();
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [APB_AW-1:0] ad, input logic [31:0] wd);
        @(posedge i_ref_clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge i_ref_clk);
        pen <= 1'b1;
        do @(posedge i_ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // two side clock periods on the input (0) or output (1) side
    task automatic run(input logic o);
        in_go <= !o;
        out_go <= o;
        repeat (12) @(posedge i_ref_clk);
        in_go <= 1'b0;
        out_go <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
    endtask
    // both addresses set alike so single-port mode sees one location
    task automatic mwr(input logic [7:0] ad, input logic [15:0] wd, input logic g);
        req <= '{wr_data: wd, wr_addr: ad, rd_addr: ad, default: 1'b0};
        stb <= {!g, g, 2'b00};
        run(1'b0);
        stb <= '0;
        run(1'b0);
    endtask
    task automatic mrd(input logic [7:0] ad, input logic g);
        req.rd_addr <= ad;
        req.wr_addr <= ad;
        stb <= {2'b00, !g, g};
        run(1'b0);
        run(1'b1);
        run(1'b1);
        stb <= '0;
    endtask
    // hang guard, far beyond the roughly 1200 cycles the run needs
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(r, 32'h3F);
        chk(rd_data, 32'h0);
        apb(1'b1, 12'h00C, 32'h1);
        chk(e, 32'h1);
        apb(1'b1, ADDR_STATUS, 32'hFFFF);
        chk(e, 32'h0);
        foreach (rows[i])
        begin
            {c, a, d} = rows[i];
            apb(1'b1, ADDR_CTRL, {23'h0, c});
            mwr(a, d, c[CTRL_WR_STB_GLOBAL]);
            mrd(a, c[CTRL_RD_STB_GLOBAL]);
            chk(rd_data, d);
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk(r[15:0], d);
        end
        // output enable low: the output register keeps its word
        apb(1'b1, ADDR_CTRL, 32'h3F);
        mwr(8'h20, 16'hBEEF, 1'b0);
        mrd(8'h20, 1'b0);
        chk(rd_data, 32'h0000BEEF);
        out_en <= 1'b0;
        mwr(8'h20, 16'hCAFE, 1'b0);
        mrd(8'h20, 1'b0);
        chk(rd_data, 32'h0000BEEF);
        out_en <= 1'b1;
        // input clear held: the write is blocked
        in_clr <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        mwr(8'h20, 16'h5555, 1'b0);
        in_clr <= 1'b0;
        mrd(8'h20, 1'b0);
        chk(rd_data, 32'h0000CAFE);
        // output, global and device clears in turn
        apb(1'b1, ADDR_CTRL, 32'h3E);
        for (int k = 0; k < 3; k++)
        begin
            cl = 3'b001 << k;
            mrd(8'h20, 1'b0);
            chk(rd_data, 32'h0000CAFE);
            out_clr <= cl[0];
            glb_clr <= cl[1];
            dev_n <= !cl[2];
            repeat (6) @(posedge i_ref_clk);
            chk(rd_data, 32'h0);
            out_clr <= 1'b0;
            glb_clr <= 1'b0;
            dev_n <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
        end
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(r, 32'h3F);
        // mid-run reset: output and control return to their reset values
        apb(1'b1, ADDR_CTRL, 32'h3E);
        mrd(8'h20, 1'b0);
        chk(rd_data, 32'h0000CAFE);
        i_reset <= 1'b1;
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        chk(rd_data, 32'h0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(r, 32'h3F);
        end_of_test();
    end
endmodule
bind embedded_memory_block emb_mem_chk #(.DEV_CLR_ENABLE(DEV_CLR_ENABLE)) chk_u (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_out_clear(i_out_clear),
    .i_global_clear(i_global_clear), .i_device_wide_clear_n(i_device_wide_clear_n),
    .o_rd_data(o_rd_data), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr));
`default_nettype wire
